// ---- shared/fso_pkg.sv ----
package fso_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int PRESC_W = 17;

  // ----------------------------------------
  // Fault source positions
  // ----------------------------------------
  localparam int NSRC = 11;
  localparam int SRC_QA_WD = 0;
  localparam int SRC_PRUN_WD = 1;
  localparam int SRC_BOOST_TEMP = 2;
  localparam int SRC_BUCK_TEMP = 3;
  localparam int SRC_IO_TEMP = 4;
  localparam int SRC_PUMP_TEMP = 5;
  localparam int SRC_IO_UVOV = 6;
  localparam int SRC_CORE_UVOV = 7;
  localparam int SRC_FIVE_UVOV = 8;
  localparam int SRC_SPI = 9;
  localparam int SRC_WEAK = 10;

  // ----------------------------------------
  // Reset values and limits
  // ----------------------------------------
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] CNT_MAX = 4'h8;
  localparam logic [NSRC-1:0] FLAGS_RST = 11'h000;
  localparam logic [6:0] DLY_RST = 7'h00;

  // Delay in whole 1 ms ticks, each inside its window
  localparam logic [2:0] DCODE_ZERO = 3'h0;
  localparam logic [6:0] DLY_C1 = 7'h01;
  localparam logic [6:0] DLY_C2 = 7'h03;
  localparam logic [6:0] DLY_C3 = 7'h07;
  localparam logic [6:0] DLY_C4 = 7'h09;
  localparam logic [6:0] DLY_C5 = 7'h1D;
  localparam logic [6:0] DLY_C6 = 7'h31;
  localparam logic [6:0] DLY_C7 = 7'h63;

  typedef enum logic [1:0] {
    FSO_IDLE = 2'b00,
    FSO_DELAY = 2'b01,
    FSO_SAFE = 2'b10
  } fso_state_t;

  function automatic logic [6:0] fso_delay_ticks(input logic [2:0] code);
    logic [6:0] t;
    t = DLY_RST;
    case (code)
      3'h1: t = DLY_C1;
      3'h2: t = DLY_C2;
      3'h3: t = DLY_C3;
      3'h4: t = DLY_C4;
      3'h5: t = DLY_C5;
      3'h6: t = DLY_C6;
      3'h7: t = DLY_C7;
      default: t = DLY_RST;
    endcase
    return t;
  endfunction

endpackage

// ---- rtl/fso_top.sv ----
`timescale 1ns/1ps

module fso_top
  import fso_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic QA_WD_ERR,
  input wire logic PRUN_WD_ERR,
  input wire logic BOOST_OVERTEMP,
  input wire logic BUCK_OVERTEMP,
  input wire logic IO_RAIL_OVERTEMP,
  input wire logic CHARGE_PUMP_OVERTEMP,
  input wire logic IO_RAIL_UVOV,
  input wire logic CORE_RAIL_UVOV,
  input wire logic FIVE_VOLT_RAIL_UVOV,
  input wire logic SPI_ERR,
  input wire logic WEAK_SUPPLY,
  input wire logic WD_MASK,
  input wire logic THERMAL_MASK,
  input wire logic UC_VOLTAGE_MASK,
  input wire logic [2:0] TOLERANCE,
  input wire logic [2:0] DELAY_CODE,
  input wire logic FLAG_READ,
  input wire logic READ_SPI_ERR,
  input wire logic PRE_REGULATOR_RAIL_UV,
  input wire logic IO_RAIL_UV,
  input wire logic FIVE_VOLT_RAIL_UV,
  input wire logic CORE_RAIL_UV,
  input wire logic WAKE_POWER_DOWN,
  output logic FAIL_SAFE_N_OUTPUT,
  output logic [NSRC-1:0] FAIL_FLAGS,
  output logic [3:0] FAULT_COUNT,
  output logic IN_FAIL_SAFE,
  output logic OUTPUT_ENABLED
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_q1;
  logic rst_n_s;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_q1 <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n_s <= rst_q1;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n_s);

  // ----------------------------------------
  // Fault masking
  // ----------------------------------------
  logic [NSRC-1:0] live;
  logic [NSRC-1:0] live_q_r;
  logic [NSRC-1:0] flags_r;
  logic [3:0] count_r;
  logic read_ok;
  logic all_clear;
  always_comb begin
    live = '0;
    live[SRC_QA_WD] = QA_WD_ERR & ~WD_MASK;
    live[SRC_PRUN_WD] = PRUN_WD_ERR & ~WD_MASK;
    live[SRC_BOOST_TEMP] = BOOST_OVERTEMP & ~THERMAL_MASK;
    live[SRC_BUCK_TEMP] = BUCK_OVERTEMP & ~THERMAL_MASK;
    live[SRC_IO_TEMP] = IO_RAIL_OVERTEMP & ~THERMAL_MASK;
    live[SRC_PUMP_TEMP] = CHARGE_PUMP_OVERTEMP & ~THERMAL_MASK;
    live[SRC_IO_UVOV] = IO_RAIL_UVOV & ~UC_VOLTAGE_MASK;
    live[SRC_CORE_UVOV] = CORE_RAIL_UVOV & ~UC_VOLTAGE_MASK;
    live[SRC_FIVE_UVOV] = FIVE_VOLT_RAIL_UVOV & ~UC_VOLTAGE_MASK;
    live[SRC_SPI] = SPI_ERR;
    live[SRC_WEAK] = WEAK_SUPPLY;
  end

  assign read_ok = FLAG_READ & ~READ_SPI_ERR;
  assign all_clear = read_ok & (live == '0);

  // ----------------------------------------
  // Failure flags
  // ----------------------------------------
  // live fault wins over the read clear
  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      flags_r <= FLAGS_RST;
      live_q_r <= FLAGS_RST;
    end else begin
      flags_r <= live | (flags_r & ~{NSRC{read_ok}});
      live_q_r <= live;
    end
  end

  // ----------------------------------------
  // Fault tolerance counter
  // ----------------------------------------
  // one step per cycle with any new fault event, stops at CNT_MAX
  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      count_r <= CNT_RST;
    end else if (all_clear) begin
      count_r <= CNT_RST;
    end else if (((live & ~live_q_r) != '0) && (count_r != CNT_MAX)) begin
      count_r <= count_r + 4'h1;
    end
  end

  // ----------------------------------------
  // Delay tick
  // ----------------------------------------
  fso_state_t state_r;
  fso_state_t state_nxt;
  logic [PRESC_W-1:0] presc_r;
  logic [6:0] dly_r;
  logic tick;

  // 1 ms tick restarted at each delay start
  assign tick = (presc_r == PRESC_W'(TICK_CYCLES - 1));

  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      presc_r <= '0;
    end else if (state_r != FSO_DELAY || tick) begin
      presc_r <= '0;
    end else begin
      presc_r <= presc_r + PRESC_W'(1);
    end
  end

  // load ticks for the chosen window
  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      dly_r <= DLY_RST;
    end else if (state_r == FSO_IDLE) begin
      dly_r <= fso_delay_ticks(DELAY_CODE);
    end else if (state_r == FSO_DELAY && tick) begin
      dly_r <= dly_r - 7'h01;
    end
  end

  // ----------------------------------------
  // Fail-safe sequencer
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      // tolerance code n allows n events
      FSO_IDLE: begin
        if (!all_clear && count_r > {1'b0, TOLERANCE}) begin
          state_nxt = (DELAY_CODE == DCODE_ZERO) ? FSO_SAFE : FSO_DELAY;
        end
      end
      FSO_DELAY: begin
        if (all_clear) begin
          state_nxt = FSO_IDLE;
        end else if (tick && dly_r == 7'h01) begin
          state_nxt = FSO_SAFE;
        end
      end
      // leave only on clean read, faults gone
      FSO_SAFE: begin
        if (all_clear) begin
          state_nxt = FSO_IDLE;
        end
      end
      default: state_nxt = FSO_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_r <= FSO_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Output enable and pin
  // ----------------------------------------
  logic en_r;
  logic pin_n_r;
  logic safe_r;

  // hold until wake power-down or pre-regulator UV
  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      en_r <= 1'b0;
    end else if (WAKE_POWER_DOWN || PRE_REGULATOR_RAIL_UV) begin
      en_r <= 1'b0;
    end else if (!IO_RAIL_UV && !FIVE_VOLT_RAIL_UV && !CORE_RAIL_UV) begin
      en_r <= 1'b1;
    end
  end

  // active low, one cycle behind the state
  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pin_n_r <= 1'b1;
      safe_r <= 1'b0;
    end else begin
      pin_n_r <= !(state_r == FSO_SAFE && en_r);
      safe_r <= (state_nxt == FSO_SAFE);
    end
  end

  assign FAIL_SAFE_N_OUTPUT = pin_n_r;
  assign FAIL_FLAGS = flags_r;
  assign FAULT_COUNT = count_r;
  assign IN_FAIL_SAFE = safe_r;
  assign OUTPUT_ENABLED = en_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  int dly_cyc;
  logic [6:0] ticks_ld;

  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      dly_cyc <= 0;
      ticks_ld <= DLY_RST;
    end else if (state_r == FSO_DELAY) begin
      dly_cyc <= dly_cyc + 1;
    end else begin
      dly_cyc <= 0;
      ticks_ld <= fso_delay_ticks(DELAY_CODE);
    end
  end
  sequence s_disable;
    !en_r ##1 pin_n_r;
  endsequence
  sequence s_safe_hold;
    (state_r == FSO_SAFE) ##1 (state_r == FSO_SAFE);
  endsequence
  chk_pin_low_cause: assert property (
    $fell(pin_n_r) |-> $past(state_r == FSO_SAFE && en_r))
    else $error("pin fell without fail-safe state");
  chk_spi_never_masked: assert property (
    SPI_ERR |=> flags_r[SRC_SPI])
    else $error("SPI error did not set its flag");
  chk_wd_mask_blocks: assert property (
    $rose(flags_r[SRC_QA_WD]) |-> $past(QA_WD_ERR && !WD_MASK))
    else $error("masked watchdog error set a flag");
  chk_flag_err_keep: assert property (
    (flags_r != '0 && FLAG_READ && READ_SPI_ERR) |=> (flags_r != '0))
    else $error("flags cleared by a failed read");
  chk_tol_not_met: assert property (
    (state_r == FSO_IDLE && count_r <= {1'b0, TOLERANCE})
      |=> (state_r == FSO_IDLE))
    else $error("left idle below tolerance");
  chk_exit_needs_read: assert property (
    (state_r == FSO_SAFE && !all_clear) |-> s_safe_hold)
    else $error("left fail-safe without clean read");
  chk_read_clears_cnt: assert property (
    all_clear |=> (count_r == CNT_RST && state_r != FSO_SAFE))
    else $error("clean read did not reset counter");
  chk_enable_drop: assert property (
    PRE_REGULATOR_RAIL_UV |=> s_disable)
    else $error("pin not disabled on pre-regulator UV");
  chk_delay_length: assert property (
    (state_r == FSO_DELAY && state_nxt == FSO_SAFE)
      |-> (dly_cyc + 1 == TICK_CYCLES * int'(ticks_ld)))
    else $error("assertion delay length wrong");
  chk_flag_hold: assert property (
    (flags_r[SRC_SPI] && SPI_ERR) |=> flags_r[SRC_SPI])
    else $error("flag cleared while fault present");

endmodule

// ---- sim/fso_host.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Host read model
// ----------------------------------------
module fso_host (
  input wire logic clk,
  input wire logic rd_req,
  input wire logic rd_bad,
  output logic flag_read,
  output logic read_spi_err
);
  // host read of flags
  // Registered, so a read always lands one edge after the request
  always @(posedge clk) begin
    flag_read <= rd_req;
    read_spi_err <= rd_req & rd_bad;
  end
endmodule

// ---- sim/tb_fso_top.sv ----
`timescale 1ns/1ps

module tb_fso_top
  import fso_pkg::*;
;
  localparam int TK = 4;
  logic clk = 1'b0, rst_n = 1'b0, rd_req = 1'b0, rd_bad = 1'b0;
  logic fr, rse, wdm = 1'b1, thm = 1'b1, ucm = 1'b1, wake = 1'b0;
  logic [10:0] flt = 11'h000;
  logic [3:0] uv = 4'hF;
  logic [2:0] tol = 3'h0, dc = 3'h0;
  logic pin, infs, oen;
  logic [NSRC-1:0] flags;
  logic [3:0] cnt;
  int error_cnt = 0, n_compared = 0, k;
  int dt[8] = '{0, 1, 3, 7, 9, 29, 49, 99};

  always #5 clk = ~clk;

  fso_host host (.clk(clk), .rd_req(rd_req), .rd_bad(rd_bad),
    .flag_read(fr), .read_spi_err(rse));

  fso_top #(.TICK_CYCLES(TK)) uut (.CLOCK(clk), .RST_N(rst_n),
    .QA_WD_ERR(flt[0]), .PRUN_WD_ERR(flt[1]), .BOOST_OVERTEMP(flt[2]),
    .BUCK_OVERTEMP(flt[3]), .IO_RAIL_OVERTEMP(flt[4]),
    .CHARGE_PUMP_OVERTEMP(flt[5]), .IO_RAIL_UVOV(flt[6]),
    .CORE_RAIL_UVOV(flt[7]), .FIVE_VOLT_RAIL_UVOV(flt[8]),
    .SPI_ERR(flt[9]), .WEAK_SUPPLY(flt[10]), .WD_MASK(wdm),
    .THERMAL_MASK(thm), .UC_VOLTAGE_MASK(ucm), .TOLERANCE(tol),
    .DELAY_CODE(dc), .FLAG_READ(fr), .READ_SPI_ERR(rse),
    .PRE_REGULATOR_RAIL_UV(uv[0]), .IO_RAIL_UV(uv[1]),
    .FIVE_VOLT_RAIL_UV(uv[2]), .CORE_RAIL_UV(uv[3]),
    .WAKE_POWER_DOWN(wake), .FAIL_SAFE_N_OUTPUT(pin), .FAIL_FLAGS(flags),
    .FAULT_COUNT(cnt), .IN_FAIL_SAFE(infs), .OUTPUT_ENABLED(oen));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // One-cycle fault event, results settled on return
  task automatic pulse(input int i);
    flt[i] = 1'b1;
    tick(1);
    flt[i] = 1'b0;
    tick(3);
  endtask

  task automatic rd(input logic bad);
    rd_req = 1'b1;
    rd_bad = bad;
    tick(1);
    rd_req = 1'b0;
    rd_bad = 1'b0;
    tick(3);
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    tick(10);
    rst_n = 1'b1;
    tick(3);
    cmp(16'(pin), 16'h1);
    pulse(SRC_SPI);
    cmp(16'(infs), 16'h1);
    cmp(16'(pin), 16'h1);
    uv = 4'h0;
    tick(3);
    cmp(16'(oen), 16'h1);
    cmp(16'(pin), 16'h0);
    uv[1] = 1'b1;
    tick(3);
    cmp(16'(oen), 16'h1);
    uv[1] = 1'b0;
    flt[SRC_SPI] = 1'b1;
    rd(1'b0);
    cmp(16'(flags), 16'h200);
    cmp(16'(infs), 16'h1);
    flt[SRC_SPI] = 1'b0;
    rd(1'b1);
    cmp(16'(flags), 16'h200);
    cmp(16'(pin), 16'h0);
    rd(1'b0);
    cmp(16'({cnt, pin, flags}), 16'h0800);
    for (int i = 0; i < 9; i++) pulse(i);
    cmp(16'({cnt, flags}), 16'h0);
    {wdm, thm, ucm, tol} = {3'b000, 3'h7};
    for (int i = 0; i < NSRC; i++) begin
      pulse(i);
      if (i == 6) cmp(16'(infs), 16'h0);
    end
    cmp(16'({cnt, flags}), 16'h47FF);
    cmp(16'(infs), 16'h1);
    rd(1'b0);
    tol = 3'h0;
    for (int c = 0; c < 8; c++) begin
      dc = 3'(c);
      flt[SRC_SPI] = 1'b1;
      k = 0;
      while (pin !== 1'b0 && k < 1000) begin
        tick(1);
        flt[SRC_SPI] = 1'b0;
        k++;
      end
      cmp(16'(k), 16'(dt[c] * TK + 3));
      rd(1'b0);
    end
    dc = 3'h0;
    pulse(SRC_WEAK);
    wake = 1'b1;
    tick(3);
    cmp(16'({oen, pin, infs}), 16'h3);
    wake = 1'b0;
    tick(3);
    uv[0] = 1'b1;
    tick(3);
    cmp(16'({oen, pin}), 16'h1);
    end_of_test;
  end

  initial begin
    #200000;
    error_cnt++;
    end_of_test;
  end
endmodule
